// ---- hdl/nand_array_op_sequencer.sv ----
// NAND array operation sequencer: serial link front end and array control
`timescale 1ns/10ps

module seq_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] f0_r;
  logic [W-1:0] f1_r;
  logic [W-1:0] f2_r;
  logic [W-1:0] q_nxt;

  // Accept a level once the second and third stages agree
  always_comb
  begin
    q_nxt = (f2_r & ~(f1_r ^ f2_r)) | (q & (f1_r ^ f2_r));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      f0_r <= RST_VAL;
      f1_r <= RST_VAL;
      f2_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      f0_r <= d;
      f1_r <= f0_r;
      f2_r <= f1_r;
      q <= q_nxt;
    end
  end
endmodule : seq_pin_sync

module nand_array_op_sequencer #(
  parameter int unsigned ERASE_CYCLES =
    nand_seq_pkg::ERASE_TIME_US * nand_seq_pkg::CLK_MHZ,
  parameter int unsigned PROG_CYCLES =
    nand_seq_pkg::PROG_TIME_US * nand_seq_pkg::CLK_MHZ,
  parameter int unsigned PAGE_LOAD_CYCLES =
    nand_seq_pkg::PAGE_LOAD_TIME_US * nand_seq_pkg::CLK_MHZ
) (
  // System clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Serial link from the host
  input wire logic SCLK_IN,
  input wire logic SEL_N_IN,
  input wire logic [3:0] IO_IN,
  // Configuration bits
  input wire nand_seq_pkg::cfg_s CFG_IN,
  // Status
  output logic BUSY_OUT,
  output logic WRITE_LATCH_OUT,
  output logic PARITY_ERR_OUT,
  // Array access
  output nand_seq_pkg::array_wr_s ARRAY_WR_OUT,
  output nand_seq_pkg::array_rd_s ARRAY_RD_OUT,
  input wire logic [7:0] ARRAY_RDATA_IN,
  // Buffer read port
  input wire nand_seq_pkg::buf_rd_req_s BUF_RD_IN,
  output nand_seq_pkg::buf_rd_rsp_s BUF_RD_OUT
);
  // ---------------- Link domain ----------------
  logic link_clr;
  logic serial_in;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [2:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [11:0] column_addr_r, column_addr_nxt;
  nand_seq_pkg::frame_s frame_r, frame_nxt;
  nand_seq_pkg::load_word_s word_r, word_nxt;
  logic frame_tog_r, frame_tog_nxt;
  logic word_tog_r, word_tog_nxt;
  logic quad_op, load_op, quad_phase, byte_done;

  assign link_clr = SEL_N_IN | RST_IN;
  assign serial_in = IO_IN[0];

  always_comb
  begin
    quad_op = frame_r.opcode == nand_seq_pkg::OP_QLOAD ||
              frame_r.opcode == nand_seq_pkg::OP_QRLOAD;
    load_op = quad_op || frame_r.opcode == nand_seq_pkg::OP_LOAD ||
              frame_r.opcode == nand_seq_pkg::OP_RLOAD;
    quad_phase = quad_op && byte_cnt_r >= nand_seq_pkg::LEN_LOAD_HDR;
    shift_nxt = quad_phase ? {shift_r[3:0], IO_IN}
                           : {shift_r[6:0], serial_in};
    bit_cnt_nxt = bit_cnt_r + (quad_phase ? nand_seq_pkg::STEP_QUAD
                                          : nand_seq_pkg::STEP_SINGLE);
    byte_done = bit_cnt_nxt == 3'h0;
    byte_cnt_nxt = byte_cnt_r;
    if (byte_done && byte_cnt_r != nand_seq_pkg::LEN_SAT)
      byte_cnt_nxt = byte_cnt_r + 3'h1;
    frame_nxt = frame_r;
    frame_nxt.nbytes = byte_cnt_nxt;
    frame_nxt.aligned = byte_done;
    frame_tog_nxt = frame_tog_r;
    if (bit_cnt_r == 3'h0 && byte_cnt_r == 3'h0)
      frame_tog_nxt = ~frame_tog_r;
    column_addr_nxt = column_addr_r;
    word_nxt = word_r;
    word_tog_nxt = word_tog_r;
    if (byte_done)
    begin
      if (byte_cnt_r == 3'h0)
        frame_nxt.opcode = shift_nxt;
      else if (byte_cnt_r <= nand_seq_pkg::LEN_ADDR - 3'h1)
        frame_nxt.page = {frame_r.page[7:0], shift_nxt};
      if (byte_cnt_r == nand_seq_pkg::LEN_LOAD_HDR - 3'h1)
        column_addr_nxt = {frame_r.page[3:0], shift_nxt};
      else if (byte_cnt_r >= nand_seq_pkg::LEN_LOAD_HDR && load_op)
      begin
        word_nxt.first = byte_cnt_r == nand_seq_pkg::LEN_LOAD_HDR;
        word_nxt.resetting = frame_r.opcode == nand_seq_pkg::OP_LOAD ||
                             frame_r.opcode == nand_seq_pkg::OP_QLOAD;
        word_nxt.quad = quad_op;
        word_nxt.col = column_addr_r;
        word_nxt.data = shift_nxt;
        word_tog_nxt = ~word_tog_r;
        if (column_addr_r <= nand_seq_pkg::LAST_COL)
          column_addr_nxt = column_addr_r + 12'h1;
      end
    end
  end

  // Counters restart with every frame
  always_ff @(posedge SCLK_IN or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      column_addr_r <= 12'h000;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r <= shift_nxt;
      column_addr_r <= column_addr_nxt;
    end
  end

  // Held between frames for the system side to sample
  always_ff @(posedge SCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      frame_r <= '0;
      word_r <= '0;
      frame_tog_r <= 1'b0;
      word_tog_r <= 1'b0;
    end
    else
    begin
      frame_r <= frame_nxt;
      word_r <= word_nxt;
      frame_tog_r <= frame_tog_nxt;
      word_tog_r <= word_tog_nxt;
    end
  end

  // ---------------- System domain ----------------
  logic [2:0] sync_q;
  logic sel_f, frame_tog_f, word_tog_f;

  seq_pin_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk(CLK_IN),
    .rst(RST_IN),
    .d({SEL_N_IN, frame_tog_r, word_tog_r}),
    .q(sync_q)
  );
  assign {sel_f, frame_tog_f, word_tog_f} = sync_q;

  nand_seq_pkg::seq_state_e state_r, state_nxt;
  logic write_latch_flag_r, write_latch_flag_nxt;
  logic sel_prev_r, sel_prev_nxt;
  logic frame_seen_r, frame_seen_nxt;
  logic word_seen_r, word_seen_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [11:0] scol_r, scol_nxt;
  logic [5:0] spage_r, spage_nxt;
  logic sdone_r, sdone_nxt;
  logic [15:0] page_r, page_nxt;
  logic [3:0][7:0] parity_r, parity_nxt;
  logic parity_err_r, parity_err_nxt;
  logic [nand_seq_pkg::PAGE_BYTES-1:0] valid_r, valid_nxt;
  nand_seq_pkg::array_wr_s wr_r, wr_nxt;
  nand_seq_pkg::array_rd_s rd_r, rd_nxt;
  nand_seq_pkg::buf_rd_rsp_s rsp_r, rsp_nxt;
  logic [7:0] mem [nand_seq_pkg::PAGE_BYTES];
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wd;
  logic [7:0] stream_byte;
  logic stream_last, parity_slot, rd_slot;

  // Unwritten bytes of a resetting load read as erased
  function automatic logic [7:0] buf_byte(input logic [11:0] col);
    buf_byte = valid_r[col] ? mem[col] : nand_seq_pkg::ERASED_BYTE;
  endfunction : buf_byte

  function automatic logic is_protected(input logic [15:0] page,
                                        input nand_seq_pkg::cfg_s c);
    logic [10:0] blk;
    logic [10:0] span;
    blk = {1'b0, page[15:6]};
    span = 11'h1 << ({1'b0, c.protect_range_bits} +
                     nand_seq_pkg::RANGE_SHIFT);
    if (c.protect_range_bits == nand_seq_pkg::RANGE_NONE)
      is_protected = 1'b0;
    else if (c.protect_range_bits == nand_seq_pkg::RANGE_ALL)
      is_protected = 1'b1;
    else if (c.protect_top_bottom)
      is_protected = blk < span;
    else
      is_protected = blk >= nand_seq_pkg::BLOCK_COUNT - span;
  endfunction : is_protected

  always_comb
  begin
    state_nxt = state_r;
    write_latch_flag_nxt = write_latch_flag_r;
    sel_prev_nxt = sel_f;
    frame_seen_nxt = frame_seen_r;
    word_seen_nxt = word_seen_r;
    timer_nxt = timer_r;
    scol_nxt = scol_r;
    spage_nxt = spage_r;
    sdone_nxt = sdone_r;
    page_nxt = page_r;
    parity_nxt = parity_r;
    parity_err_nxt = parity_err_r;
    valid_nxt = valid_r;
    wr_nxt = '0;
    rd_nxt = '0;
    rsp_nxt = '0;
    mem_we = 1'b0;
    mem_addr = word_r.col;
    mem_wd = word_r.data;
    if (timer_r != 32'h0)
      timer_nxt = timer_r - 32'h1;
    stream_last = scol_r == nand_seq_pkg::LAST_COL &&
      (state_r != nand_seq_pkg::ST_ERASE ||
       spage_r == nand_seq_pkg::LAST_PAGE_IN_BLOCK);
    parity_slot = CFG_IN.parity_en && scol_r >= nand_seq_pkg::MAIN_BYTES &&
                  scol_r[3:0] == nand_seq_pkg::PARITY_SLOT;
    stream_byte = parity_slot ? parity_r[scol_r[5:4]]
                              : buf_byte(scol_r);
    rd_slot = CFG_IN.parity_en && rd_r.col >= nand_seq_pkg::MAIN_BYTES &&
              rd_r.col[3:0] == nand_seq_pkg::PARITY_SLOT;

    // Streaming pass over the page or block
    if (state_r != nand_seq_pkg::ST_IDLE && !sdone_r)
    begin
      scol_nxt = (scol_r == nand_seq_pkg::LAST_COL) ? 12'h000
                                                     : scol_r + 12'h1;
      if (scol_r == nand_seq_pkg::LAST_COL)
        spage_nxt = spage_r + 6'h1;
      sdone_nxt = stream_last;
      case (state_r)
        nand_seq_pkg::ST_ERASE:
          wr_nxt = {1'b1, page_r[15:6], spage_r, scol_r,
                    nand_seq_pkg::ERASED_BYTE};
        nand_seq_pkg::ST_PROG:
        begin
          wr_nxt = {1'b1, page_r, scol_r, stream_byte};
          if (scol_r < nand_seq_pkg::MAIN_BYTES)
            parity_nxt[scol_r[10:9]] = parity_r[scol_r[10:9]] ^
                                       buf_byte(scol_r);
        end
        nand_seq_pkg::ST_READ:
          rd_nxt = {1'b1, page_r, scol_r};
        default:
          rd_nxt = '0;
      endcase
    end

    // Array data is sampled in the same cycle as each read request on ARRAY_RD_OUT
    if (rd_r.en)
    begin
      mem_we = 1'b1;
      mem_addr = rd_r.col;
      mem_wd = ARRAY_RDATA_IN;
      valid_nxt[rd_r.col] = 1'b1;
      if (rd_r.col < nand_seq_pkg::MAIN_BYTES)
        parity_nxt[rd_r.col[10:9]] = parity_r[rd_r.col[10:9]] ^
                                     ARRAY_RDATA_IN;
      else if (rd_slot && parity_r[rd_r.col[5:4]] != ARRAY_RDATA_IN)
        parity_err_nxt = 1'b1;
    end

    // Busy ends once both the timer and the pass are done
    if (state_r != nand_seq_pkg::ST_IDLE && sdone_r && timer_r == 32'h0 &&
        !rd_r.en)
    begin
      state_nxt = nand_seq_pkg::ST_IDLE;
      if (state_r != nand_seq_pkg::ST_READ)
        write_latch_flag_nxt = 1'b0;
    end

    // Buffer load bytes from the link
    if (word_tog_f != word_seen_r)
    begin
      word_seen_nxt = word_tog_f;
      if (state_r == nand_seq_pkg::ST_IDLE && write_latch_flag_r &&
          !(word_r.quad && CFG_IN.wp_en))
      begin
        if (word_r.first && word_r.resetting)
          valid_nxt = '0;
        if (word_r.col <= nand_seq_pkg::LAST_COL)
        begin
          mem_we = 1'b1;
          valid_nxt[word_r.col] = 1'b1;
        end
      end
    end

    // Buffer read port
    if (BUF_RD_IN.req && state_r == nand_seq_pkg::ST_IDLE)
    begin
      rsp_nxt.valid = 1'b1;
      if (BUF_RD_IN.col > nand_seq_pkg::LAST_COL)
        rsp_nxt.at_end = 1'b1;
      else
        rsp_nxt.data = buf_byte(BUF_RD_IN.col);
      if (BUF_RD_IN.col == nand_seq_pkg::LAST_COL && !CFG_IN.read_mode)
      begin
        state_nxt = nand_seq_pkg::ST_READ;
        page_nxt = page_r + 16'h1;
        timer_nxt = 32'(PAGE_LOAD_CYCLES);
        scol_nxt = 12'h000;
        sdone_nxt = 1'b0;
        parity_nxt = '0;
        parity_err_nxt = 1'b0;
      end
    end

    // Commands taken when select rises
    if (sel_f && !sel_prev_r && frame_tog_f != frame_seen_r)
    begin
      frame_seen_nxt = frame_tog_f;
      if (state_r == nand_seq_pkg::ST_IDLE && frame_r.aligned)
      begin
        scol_nxt = 12'h000;
        spage_nxt = 6'h00;
        sdone_nxt = 1'b0;
        parity_nxt = '0;
        page_nxt = frame_r.page;
        if (frame_r.nbytes == nand_seq_pkg::LEN_SHORT &&
            frame_r.opcode == nand_seq_pkg::OP_WRITE_EN)
          write_latch_flag_nxt = 1'b1;
        else if (frame_r.nbytes == nand_seq_pkg::LEN_ADDR)
        begin
          case (frame_r.opcode)
            nand_seq_pkg::OP_ERASE:
              if (write_latch_flag_r &&
                  !is_protected(frame_r.page, CFG_IN))
              begin
                state_nxt = nand_seq_pkg::ST_ERASE;
                timer_nxt = 32'(ERASE_CYCLES);
              end
            nand_seq_pkg::OP_PROG_EXEC:
              if (!is_protected(frame_r.page, CFG_IN))
              begin
                state_nxt = nand_seq_pkg::ST_PROG;
                timer_nxt = 32'(PROG_CYCLES);
              end
            nand_seq_pkg::OP_PAGE_READ:
            begin
              state_nxt = nand_seq_pkg::ST_READ;
              timer_nxt = 32'(PAGE_LOAD_CYCLES);
              parity_err_nxt = 1'b0;
            end
            default:
              state_nxt = state_r;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_r <= nand_seq_pkg::ST_IDLE;
      write_latch_flag_r <= 1'b0;
      sel_prev_r <= 1'b1;
      frame_seen_r <= 1'b0;
      word_seen_r <= 1'b0;
      timer_r <= 32'h0;
      scol_r <= 12'h000;
      spage_r <= 6'h00;
      sdone_r <= 1'b1;
      page_r <= 16'h0000;
      parity_r <= '0;
      parity_err_r <= 1'b0;
      valid_r <= '0;
      wr_r <= '0;
      rd_r <= '0;
      rsp_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      write_latch_flag_r <= write_latch_flag_nxt;
      sel_prev_r <= sel_prev_nxt;
      frame_seen_r <= frame_seen_nxt;
      word_seen_r <= word_seen_nxt;
      timer_r <= timer_nxt;
      scol_r <= scol_nxt;
      spage_r <= spage_nxt;
      sdone_r <= sdone_nxt;
      page_r <= page_nxt;
      parity_r <= parity_nxt;
      parity_err_r <= parity_err_nxt;
      valid_r <= valid_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Data buffer storage
  always_ff @(posedge CLK_IN)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wd;
  end

  assign BUSY_OUT = state_r != nand_seq_pkg::ST_IDLE;
  assign WRITE_LATCH_OUT = write_latch_flag_r;
  assign PARITY_ERR_OUT = parity_err_r;
  assign ARRAY_WR_OUT = wr_r;
  assign ARRAY_RD_OUT = rd_r;
  assign BUF_RD_OUT = rsp_r;
endmodule : nand_array_op_sequencer

// ---- hdl/nand_seq_pkg.sv ----
// Constants and carrier types for the NAND array operation sequencer
package nand_seq_pkg;
  // System clock and self-timed cycle lengths
  localparam int CLK_MHZ = 100;
  localparam int ERASE_TIME_US = 2000;
  localparam int PROG_TIME_US = 250;
  localparam int PAGE_LOAD_TIME_US = 60;
  // Opcodes
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_ERASE = 8'hd8;
  localparam logic [7:0] OP_LOAD = 8'h02;
  localparam logic [7:0] OP_RLOAD = 8'h84;
  localparam logic [7:0] OP_QLOAD = 8'h32;
  localparam logic [7:0] OP_QRLOAD = 8'h34;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  // Buffer and array geometry
  localparam int PAGE_BYTES = 2112;
  localparam logic [11:0] LAST_COL = 12'h83f;
  localparam logic [11:0] MAIN_BYTES = 12'h800;
  localparam logic [3:0] PARITY_SLOT = 4'h8;
  localparam logic [5:0] LAST_PAGE_IN_BLOCK = 6'h3f;
  localparam logic [10:0] BLOCK_COUNT = 11'h400;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Frame lengths in bytes
  localparam logic [2:0] LEN_SHORT = 3'h1;
  localparam logic [2:0] LEN_LOAD_HDR = 3'h3;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_SAT = 3'h7;
  // Bits shifted per link clock
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  // Protect range encodings
  localparam logic [2:0] RANGE_NONE = 3'h0;
  localparam logic [2:0] RANGE_ALL = 3'h7;
  localparam logic [3:0] RANGE_SHIFT = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_PROG = 2'h3,
    ST_ERASE = 2'h2
  } seq_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] page;
    logic [2:0] nbytes;
    logic aligned;
  } frame_s;

  typedef struct packed {
    logic first;
    logic resetting;
    logic quad;
    logic [11:0] col;
    logic [7:0] data;
  } load_word_s;

  typedef struct packed {
    logic protect_top_bottom;
    logic [2:0] protect_range_bits;
    logic parity_en;
    logic read_mode;
    logic wp_en;
  } cfg_s;

  typedef struct packed {
    logic en;
    logic [15:0] page;
    logic [11:0] col;
    logic [7:0] data;
  } array_wr_s;

  typedef struct packed {
    logic en;
    logic [15:0] page;
    logic [11:0] col;
  } array_rd_s;

  typedef struct packed {
    logic req;
    logic [11:0] col;
  } buf_rd_req_s;

  typedef struct packed {
    logic valid;
    logic at_end;
    logic [7:0] data;
  } buf_rd_rsp_s;
endpackage : nand_seq_pkg

// ---- tb/nand_seq_checker.sv ----
// Port-level assertions for the NAND array operation sequencer
`timescale 1ns/10ps
module nand_seq_checker (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Observed ports
  input wire logic BUSY_OUT,
  input wire logic WRITE_LATCH_OUT,
  input wire nand_seq_pkg::array_wr_s ARRAY_WR_OUT,
  input wire nand_seq_pkg::array_rd_s ARRAY_RD_OUT,
  input wire nand_seq_pkg::buf_rd_req_s BUF_RD_IN,
  input wire nand_seq_pkg::buf_rd_rsp_s BUF_RD_OUT
);
  logic wrote_r;
  logic wrote_nxt;
  // Remembers an array write within the current busy period
  always_comb
  begin
    wrote_nxt = BUSY_OUT ? (wrote_r | ARRAY_WR_OUT.en) : 1'b0;
  end
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      wrote_r <= 1'b0;
    else
      wrote_r <= wrote_nxt;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence bufrd_taken;
    BUF_RD_IN.req && !BUSY_OUT;
  endsequence
  sequence wr_pair;
    ARRAY_WR_OUT.en ##1 ARRAY_WR_OUT.en;
  endsequence
  wr_busy_a: assert property (ARRAY_WR_OUT.en |-> BUSY_OUT)
    else $error("array write while idle");
  wr_col_step_a: assert property (wr_pair ##0 ARRAY_WR_OUT.col != 12'h000
    |-> ARRAY_WR_OUT.col == $past(ARRAY_WR_OUT.col) + 12'h001)
    else $error("array write column skipped");
  latch_clear_a: assert property ($fell(BUSY_OUT) && wrote_r
    |-> !WRITE_LATCH_OUT)
    else $error("write latch kept after array cycle");
  busy_hold_a: assert property ($rose(BUSY_OUT) |-> BUSY_OUT [*8])
    else $error("busy too short");
  rd_col_a: assert property (ARRAY_RD_OUT.en
    |-> BUSY_OUT && ARRAY_RD_OUT.col <= nand_seq_pkg::LAST_COL)
    else $error("array read outside page or idle");
  bufrd_ans_a: assert property (bufrd_taken |=> BUF_RD_OUT.valid)
    else $error("buffer read unanswered");
  bufrd_busy_a: assert property (BUF_RD_OUT.valid
    |-> $past(BUF_RD_IN.req) && !$past(BUSY_OUT))
    else $error("buffer read answered while busy");
  at_end_a: assert property (bufrd_taken ##0 BUF_RD_IN.col > 12'h83f
    |=> BUF_RD_OUT.at_end && BUF_RD_OUT.data == 8'h00)
    else $error("read past buffer end not flagged");
  latch_idle_a: assert property ($rose(WRITE_LATCH_OUT) |-> !BUSY_OUT)
    else $error("write latch set while busy");
endmodule : nand_seq_checker

bind nand_array_op_sequencer nand_seq_checker i_chk (
  .CLK_IN(CLK_IN),
  .RST_IN(RST_IN),
  .BUSY_OUT(BUSY_OUT),
  .WRITE_LATCH_OUT(WRITE_LATCH_OUT),
  .ARRAY_WR_OUT(ARRAY_WR_OUT),
  .ARRAY_RD_OUT(ARRAY_RD_OUT),
  .BUF_RD_IN(BUF_RD_IN),
  .BUF_RD_OUT(BUF_RD_OUT)
);

// ---- tb/nand_host_model.sv ----
// Host side of the serial link: clock, select and data lines
`timescale 1ns/10ps
module nand_host_model (
  // Serial link
  output logic sclk_out,
  output logic sel_n_out,
  output logic [3:0] io_out
);
  initial
  begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    io_out = 4'h5;
  end
  // One link clock of 160 ns, data set while clock is low
  task automatic clk_bits(input logic [3:0] v);
    #40 io_out = v;
    #40 sclk_out = 1'b1;
    #80 sclk_out = 1'b0;
  endtask : clk_bits
  // Bytes MSB first; from index qf on, two nibbles on four lines
  task automatic frame(input logic [7:0] b[$], input int qf, input int ex);
    sel_n_out = 1'b0;
    foreach (b[i])
      if (i >= qf)
      begin
        clk_bits(b[i][7:4]);
        clk_bits(b[i][3:0]);
      end
      else
        for (int k = 7; k >= 0; k--)
          clk_bits({3'h0, b[i][k]});
    repeat (ex) clk_bits(~io_out);
    #40 sel_n_out = 1'b1;
    io_out = ~io_out;
    #100;
  endtask : frame
endmodule : nand_host_model

// ---- tb/test_nand_array_op_sequencer.sv ----
// Self-checking bench for the NAND array operation sequencer
`timescale 1ns/10ps
module test_nand_array_op_sequencer;
  logic clk, rst, busy, latch, perr, sclk, sel_n;
  logic [3:0] io;
  logic [7:0] rdata, q;
  logic [31:0] seed;
  int fail_count, check_count;
  nand_seq_pkg::cfg_s cfg;
  nand_seq_pkg::array_wr_s wr;
  nand_seq_pkg::array_rd_s rd;
  nand_seq_pkg::buf_rd_req_s bq;
  nand_seq_pkg::buf_rd_rsp_s bs;
  logic [7:0] mem [logic [27:0]];
  logic [7:0] ebuf [2112];
  logic [7:0] d [4];
  logic [7:0] ops [4] = '{8'h02, 8'h84, 8'h32, 8'h34};
  nand_array_op_sequencer #(.ERASE_CYCLES(10), .PROG_CYCLES(10),
    .PAGE_LOAD_CYCLES(10)) i_dut (.CLK_IN(clk), .RST_IN(rst),
    .SCLK_IN(sclk), .SEL_N_IN(sel_n), .IO_IN(io), .CFG_IN(cfg),
    .BUSY_OUT(busy), .WRITE_LATCH_OUT(latch), .PARITY_ERR_OUT(perr),
    .ARRAY_WR_OUT(wr), .ARRAY_RD_OUT(rd), .ARRAY_RDATA_IN(rdata),
    .BUF_RD_IN(bq), .BUF_RD_OUT(bs));
  nand_host_model i_host (.sclk_out(sclk), .sel_n_out(sel_n),
    .io_out(io));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Array: erased value when never written
  always @(posedge clk)
  begin
    if (wr.en)
      mem[{wr.page, wr.col}] = wr.data;
  end
  // Read data settles mid-cycle for the edge that captures it
  always @(negedge clk)
  begin
    rdata <= memat(rd.page, rd.col);
  end
  function automatic logic [7:0] memat(input logic [15:0] p,
    input logic [11:0] c);
    return mem.exists({p, c}) ? mem[{p, c}] : 8'hff;
  endfunction : memat
  function automatic logic [7:0] par(input int s);
    logic [7:0] x = 8'h00;
    for (int k = 0; k < 512; k++)
      x ^= ebuf[512 * s + k];
    return x;
  endfunction : par
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic send(input logic [7:0] b[$], input int qf = 99,
    input int ex = 0);
    i_host.frame(b, qf, ex);
    tick(12);
  endtask : send
  task automatic wait_done();
    int n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      tick(1);
      n++;
    end
    if (n == 20000)
    begin
      fail_count++;
      end_sim();
    end
  endtask : wait_done
  task automatic bread(input logic [11:0] c);
    bq = {1'b1, c};
    tick(1);
    bq = '0;
    check("valid", bs.valid, 1'b1);
    check("atend", bs.at_end, c > nand_seq_pkg::LAST_COL);
    tick(1);
  endtask : bread
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  initial
  begin
    #1_000_000;
    fail_count++;
    end_sim();
  end
  initial
  begin : main
    logic [11:0] col, c6;
    logic [15:0] pg;
    logic [7:0] op;
    logic [7:0] b[$];
    int n;
    seed = 32'hfbe74917;
    fail_count = 0;
    check_count = 0;
    rst = 1'b1;
    bq = '0;
    cfg = 7'h06;
    tick(10);
    rst = 1'b0;
    tick(10);
    check("busy", busy, 1'b0);
    send({8'hd8, 8'h00, 8'h01, 8'h45});
    check("busy", busy, 1'b0);
    send({nand_seq_pkg::OP_WRITE_EN});
    check("latch", latch, 1'b1);
    send({8'hd8, 8'h00, 8'h01, 8'h45}, 99, 3);
    check("busy", busy, 1'b0);
    cfg.protect_range_bits = 3'h7;
    send({8'hd8, 8'h00, 8'h01, 8'h45});
    check("busy", busy, 1'b0);
    send({nand_seq_pkg::OP_PROG_EXEC, 8'h00, 8'h01, 8'h45});
    check("busy", busy, 1'b0);
    check("latch", latch, 1'b1);
    cfg.protect_range_bits = 3'h0;
    foreach (ops[i])
    begin
      op = ops[i];
      col = 12'($unsigned($random(seed)) % 2000);
      c6 = col + 12'h006;
      n = 1 + $unsigned($random(seed)) % 4;
      pg = 16'($random(seed));
      foreach (d[k])
        d[k] = 8'($random(seed));
      send({nand_seq_pkg::OP_WRITE_EN});
      if (op[5])
      begin
        cfg.wp_en = 1'b1;
        send({op, 8'(c6[11:8]), c6[7:0], ~d[0]}, 3);
        cfg.wp_en = 1'b0;
      end
      b = {op, 8'(col[11:8]), col[7:0]};
      for (int k = 0; k < n; k++)
        b.push_back(d[k]);
      send(b, op[5] ? 3 : 99);
      if (op[1])
        foreach (ebuf[k])
          ebuf[k] = 8'hff;
      for (int k = 0; k < n; k++)
        ebuf[col + k] = d[k];
      send({nand_seq_pkg::OP_PROG_EXEC, 8'h00, pg[15:8], pg[7:0]});
      check("busy", busy, 1'b1);
      wait_done();
      check("latch", latch, 1'b0);
      for (int k = 0; k < 8; k++)
        check("array", memat(pg, col + k), ebuf[col + k]);
      q = par(int'(col[10:9]));
      check("parity", memat(pg, 12'h808 + 12'(16 * col[10:9])), q);
    end
    send({nand_seq_pkg::OP_PAGE_READ, 8'h00, pg[15:8], pg[7:0]});
    check("busy", busy, 1'b1);
    send({nand_seq_pkg::OP_WRITE_EN});
    wait_done();
    check("latch", latch, 1'b0);
    check("perr", perr, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      bq = {1'b1, col + 12'(k)};
      tick(1);
      bq = '0;
      check("bufdata", bs.data, ebuf[col + k]);
      tick(1);
    end
    bread(12'h840);
    cfg.read_mode = 1'b0;
    bread(nand_seq_pkg::LAST_COL);
    check("contbusy", busy, 1'b1);
    wait_done();
    cfg.read_mode = 1'b1;
    send({nand_seq_pkg::OP_WRITE_EN});
    send({8'hd8, 8'h00, 8'h01, 8'h45});
    check("busy", busy, 1'b1);
    n = 0;
    while (wr.en !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    check("erstart", wr.en, 1'b1);
    check("erpage", wr.page[7:0], 8'h40);
    check("erdata", wr.data, 8'hff);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    check("busy", busy, 1'b0);
    check("latch", latch, 1'b0);
    end_sim();
  end
endmodule : test_nand_array_op_sequencer
